// >>> hdl/uut_bus_status_monitor.sv
// uut_bus_status_monitor: status word, forcing line classing and control line forcing
// for a test pod standing in for the target processor.
// assumes host commands arrive as one-clock strobes with address and data.
`timescale 1ns/10ps
module uut_bus_status_monitor
    import uut_monitor_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_CYCLES_DFLT
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // host command port
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic [31:0] cmdAddr,
    input wire logic [15:0] cmdData,
    output logic [15:0] rdData,
    output logic uutCycleStart,
    // target bus inputs
    input wire logic data_transfer_ack_n,
    input wire logic peripheral_addr_valid_n,
    input wire logic address_strobe_n,
    input wire logic halt_in_n,
    input wire logic bus_request_n,
    input wire logic bus_grant_ack_n,
    input wire logic bus_error_n,
    input wire logic reset_in_n,
    input wire logic irq_priority_bit0_n,
    input wire logic irq_priority_bit1_n,
    input wire logic irq_priority_bit2_n,
    input wire logic powerFail,
    input wire logic vectorReady,
    input wire logic [CTL_W-1:0] ctlDriveFault,
    // to the pod processor
    output logic cpuHalt_n,
    output logic cpuBusRequest_n,
    output logic cpuBusGrantAck_n,
    output logic [2:0] cpuIrq_n,
    output logic vectorCollect,
    // forced control lines: level and output enable
    output logic halt_out_n,
    output logic halt_oe,
    output logic valid_memory_addr_n,
    output logic vma_oe,
    output logic bus_grant_n,
    output logic bus_grant_oe,
    output logic reset_out_n,
    output logic reset_oe,
    // reports
    output logic activeForceLine,
    output logic activeInterrupt,
    output logic ackError,
    output logic [CTL_W-1:0] control_line_fault_report
);
    ////////////////////////////////////////////////////////////////////////////
    // configuration held from host writes

    logic [ENA_W-1:0] lineEnable, next_lineEnable;
    logic [STS_W-1:0] forceMask, next_forceMask;
    logic intEnable, next_intEnable;
    logic intTrap, next_intTrap;
    logic special;
    logic wrStrobe, rdStrobe;

    // top nibble marks a pod command; it never reaches the target bus
    assign special = (cmdAddr[31:28] == SPECIAL_NIBBLE);
    assign wrStrobe = cmdValid && cmdWrite && special;
    assign rdStrobe = cmdValid && !cmdWrite && special;

    always_comb begin
        next_lineEnable = lineEnable;
        next_forceMask = forceMask;
        next_intEnable = intEnable;
        next_intTrap = intTrap;
        if (wrStrobe && cmdAddr == ADDR_FORCE_ENA) begin
            next_lineEnable = cmdData[ENA_W-1:0];
        end
        if (wrStrobe && cmdAddr == ADDR_FORCE_MASK) begin
            next_forceMask = cmdData;
        end
        if (wrStrobe && cmdAddr == ADDR_TRAP_CFG) begin
            next_intEnable = cmdData[0];
            next_intTrap = cmdData[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lineEnable <= '0;
            forceMask <= '0;
            intEnable <= 1'b0;
            intTrap <= 1'b0;
        end else if (ce) begin
            lineEnable <= next_lineEnable;
            forceMask <= next_forceMask;
            intEnable <= next_intEnable;
            intTrap <= next_intTrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // target cycle tracking: ack seen during strobe, sampled at strobe rise

    logic strobePrev, next_strobePrev;
    logic dtackSeen, next_dtackSeen;
    logic pavSeen, next_pavSeen;
    logic pavLast, next_pavLast;
    ack_capture_if acq();

    always_comb begin
        next_strobePrev = address_strobe_n;
        next_dtackSeen = dtackSeen;
        next_pavSeen = pavSeen;
        next_pavLast = pavLast;
        if (!address_strobe_n) begin
            next_dtackSeen = dtackSeen || !data_transfer_ack_n;
            next_pavSeen = pavSeen || !peripheral_addr_valid_n;
            next_pavLast = !peripheral_addr_valid_n;
        end
        if (acq.cycleEnd) begin
            next_dtackSeen = 1'b0;
            next_pavSeen = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            strobePrev <= 1'b1;
            dtackSeen <= 1'b0;
            pavSeen <= 1'b0;
            pavLast <= 1'b0;
        end else if (ce) begin
            strobePrev <= next_strobePrev;
            dtackSeen <= next_dtackSeen;
            pavSeen <= next_pavSeen;
            pavLast <= next_pavLast;
        end
    end

    // cycle ends where strobe goes high; peripheral-valid is judged there from its last strobe-low level
    assign acq.cycleEnd = !strobePrev && address_strobe_n;
    assign acq.dtackSeen = dtackSeen;
    assign acq.pavSeen = pavSeen;
    // level at the last strobe-low edge: a good target drops the line with the strobe
    assign acq.pavAtEnd = pavLast;

    ack_capture ackCap (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .acq(acq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status word and forcing line classing

    logic [STS_W-1:0] status, forcing, userEna;
    logic [STS_W-1:0] next_rdData;
    logic pulseBusy;
    logic [WCTL_W-1:0] lineLevel;

    always_comb begin
        status = '0;
        status[STS_HALT] = halt_in_n;
        status[STS_BREQ] = bus_request_n;
        status[STS_BUS_GRANT_ACK_N] = bus_grant_ack_n;
        status[STS_BUS_ERROR_N] = bus_error_n;
        status[STS_RESET] = reset_in_n;
        status[STS_PAV] = peripheral_addr_valid_n;
        status[STS_DATA_TRANSFER_ACK_N] = data_transfer_ack_n;
        status[STS_PWRFAIL] = powerFail;
        status[STS_IRQ_PRIORITY_BIT0_N] = irq_priority_bit0_n;
        status[STS_IPL1] = irq_priority_bit1_n;
        status[STS_IRQ_PRIORITY_BIT2_N] = irq_priority_bit2_n;
        status[STS_IVEC] = vectorReady && intEnable;
        status[STS_NEITHER] = acq.neitherAck;
        status[STS_BOTH] = acq.bothAck;
        // asserted forcing lines, as active-high flags
        forcing = '0;
        forcing[STS_HALT] = !halt_in_n;
        forcing[STS_BREQ] = !bus_request_n;
        forcing[STS_BUS_GRANT_ACK_N] = !bus_grant_ack_n;
        forcing[STS_BUS_ERROR_N] = !bus_error_n;
        forcing[STS_RESET] = !reset_in_n;
        forcing[STS_NEITHER] = acq.neitherAck;
        forcing[STS_BOTH] = acq.bothAck;
        // enabled lines drop out of the class; bus error and reset never do
        userEna = '0;
        userEna[STS_HALT] = lineEnable[ENA_HALT];
        userEna[STS_BREQ] = lineEnable[ENA_BRACK];
        userEna[STS_BUS_GRANT_ACK_N] = lineEnable[ENA_BRACK];
        next_rdData = rdData;
        if (rdStrobe) begin
            case (cmdAddr)
                ADDR_STATUS: next_rdData = status;
                ADDR_CTL_FAULT: next_rdData = 16'(control_line_fault_report);
                ADDR_FORCE_MASK: next_rdData = forceMask;
                default: next_rdData = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdData <= '0;
            uutCycleStart <= 1'b0;
            cpuHalt_n <= 1'b1;
            cpuBusRequest_n <= 1'b1;
            cpuBusGrantAck_n <= 1'b1;
            cpuIrq_n <= 3'h7;
            vectorCollect <= 1'b0;
            activeForceLine <= 1'b0;
            activeInterrupt <= 1'b0;
            ackError <= 1'b0;
            control_line_fault_report <= '0;
        end else if (ce) begin
            rdData <= next_rdData;
            uutCycleStart <= cmdValid && !special;
            // disabled lines are blocked but still sampled above
            cpuHalt_n <= lineEnable[ENA_HALT] ? halt_in_n : 1'b1;
            cpuBusRequest_n <= lineEnable[ENA_BRACK] ? bus_request_n : 1'b1;
            cpuBusGrantAck_n <= lineEnable[ENA_BRACK] ? bus_grant_ack_n : 1'b1;
            cpuIrq_n <= intEnable ? {irq_priority_bit2_n, irq_priority_bit1_n,
                                     irq_priority_bit0_n} : 3'h7;
            vectorCollect <= intEnable && vectorReady;
            // pod-generated ack bits report only through the mask
            activeForceLine <= |(forcing & ~userEna
                                 & ~(16'h0001 << STS_BOTH) & ~(16'h0001 << STS_NEITHER))
                               || (acq.neitherAck && forceMask[STS_NEITHER]);
            ackError <= acq.bothAck && forceMask[STS_BOTH];
            activeInterrupt <= intTrap && !(irq_priority_bit0_n && irq_priority_bit1_n
                                            && irq_priority_bit2_n);
            control_line_fault_report <= ctlDriveFault
                                         | (CTL_W'(acq.vmaFault) << CTL_VMA);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control line forcing; host pattern is levels, 0 drives low

    logic startShort, startLong;
    assign startShort = wrStrobe && cmdAddr == ADDR_WRITE_CTL;
    assign startLong = wrStrobe && cmdAddr == ADDR_RESET_CMD;

    line_pulser pulser (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .startShort(startShort),
        .startLong(startLong),
        .pattern(cmdData[WCTL_W-1:0]),
        .longCycles(CNT_W'(RESET_CYCLES)),
        .lineLevel(lineLevel),
        .busy(pulseBusy)
    );

    // registered inside the pulser; enables follow the driven-low bits
    assign halt_out_n = lineLevel[CTL_HALT];
    assign valid_memory_addr_n = lineLevel[CTL_VMA];
    assign bus_grant_n = lineLevel[CTL_BG];
    assign reset_out_n = lineLevel[CTL_RESET];
    assign halt_oe = !lineLevel[CTL_HALT];
    assign vma_oe = !lineLevel[CTL_VMA];
    assign bus_grant_oe = !lineLevel[CTL_BG];
    assign reset_oe = !lineLevel[CTL_RESET];

    ////////////////////////////////////////////////////////////////////////////

    berrForce_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !bus_error_n) |=> activeForceLine)
        else $error("bus error not reported as forcing");
    enabledQuiet_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && lineEnable == 2'h3 && bus_error_n && reset_in_n && !acq.neitherAck)
        |=> !activeForceLine)
        else $error("enabled line reported as forcing");
    haltBlocked_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !lineEnable[ENA_HALT]) |=> cpuHalt_n)
        else $error("disabled halt reached processor");
    ackMasked_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !forceMask[STS_BOTH]) |=> !ackError)
        else $error("both-ack error reported while masked");
    irqGate_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !intEnable) |=> (cpuIrq_n == 3'h7 && !vectorCollect))
        else $error("interrupt passed while disabled");
    trapOff_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !intTrap) |=> !activeInterrupt)
        else $error("interrupt reported while trap off");
    noUutCycle_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && cmdValid && special) |=> !uutCycleStart)
        else $error("special address reached target bus");
    topZero_a: assert property (@(posedge clk) disable iff (!nrst)
        rdData[15:14] == 2'h0)
        else $error("status top bits not zero");
    faultMask_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && ctlDriveFault[8]) |=> control_line_fault_report[8])
        else $error("fault bit not reported at its position");
endmodule : uut_bus_status_monitor

// >>> hdl/uut_monitor_pkg.sv
// uut_monitor_pkg: constants shared by the bus status monitor and its helpers.
// assumes the host command port delivers whole words in one clock.
package uut_monitor_pkg;
    // status word bit positions
    localparam int STS_HALT = 0;
    localparam int STS_BREQ = 1;
    localparam int STS_BUS_GRANT_ACK_N = 2;
    localparam int STS_BUS_ERROR_N = 3;
    localparam int STS_RESET = 4;
    localparam int STS_PAV = 5;
    localparam int STS_DATA_TRANSFER_ACK_N = 6;
    localparam int STS_PWRFAIL = 7;
    localparam int STS_IRQ_PRIORITY_BIT0_N = 8;
    localparam int STS_IPL1 = 9;
    localparam int STS_IRQ_PRIORITY_BIT2_N = 10;
    localparam int STS_IVEC = 11;
    localparam int STS_NEITHER = 12;
    localparam int STS_BOTH = 13;
    localparam int STS_W = 16;
    // control word bit positions
    localparam int CTL_HALT = 0;
    localparam int CTL_VMA = 1;
    localparam int CTL_BG = 2;
    localparam int CTL_RESET = 4;
    localparam int CTL_W = 13;
    localparam int WCTL_W = 5;
    // forcing line enables: halt, bus request/ack pair
    localparam int ENA_HALT = 0;
    localparam int ENA_BRACK = 1;
    localparam int ENA_W = 2;
    // special address space: top nibble marks pod-internal commands
    localparam logic [31:0] SPECIAL_BASE = 32'hf000_0000;
    localparam logic [3:0] SPECIAL_NIBBLE = 4'hf;
    localparam logic [31:0] ADDR_RESET_CMD = 32'hf000_000a;
    localparam logic [31:0] ADDR_FORCE_MASK = 32'hf000_0010;
    localparam logic [31:0] ADDR_FORCE_ENA = 32'hf000_0012;
    localparam logic [31:0] ADDR_STATUS = 32'hf000_0014;
    localparam logic [31:0] ADDR_TRAP_CFG = 32'hf000_0016;
    localparam logic [31:0] ADDR_WRITE_CTL = 32'hf000_0018;
    localparam logic [31:0] ADDR_CTL_FAULT = 32'hf000_001a;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_CYCLE_NS = 400;
    localparam int WCTL_CYCLES = BUS_CYCLE_NS / CLK_PERIOD_NS;
    localparam int RESET_PULSE_NS = 100000;
    localparam int RESET_CYCLES_DFLT = RESET_PULSE_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam logic [WCTL_W-1:0] WCTL_IDLE = 5'h1f;
    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b00,
        PULSE_SHORT = 2'b01,
        PULSE_LONG = 2'b10
    } pulse_state_type;
endpackage : uut_monitor_pkg

// >>> hdl/ack_capture_if.sv
// ack_capture_if: acknowledge sampling between the top and its capture helper.
// assumes one clock domain.
`timescale 1ns/10ps
interface ack_capture_if;
    logic cycleEnd;
    logic dtackSeen;
    logic pavSeen;
    logic pavAtEnd;
    logic bothAck;
    logic neitherAck;
    logic vmaFault;
    modport top (output cycleEnd, dtackSeen, pavSeen, pavAtEnd,
                 input bothAck, neitherAck, vmaFault);
    modport cap (input cycleEnd, dtackSeen, pavSeen, pavAtEnd,
                 output bothAck, neitherAck, vmaFault);
endinterface : ack_capture_if

// >>> hdl/ack_capture.sv
// ack_capture: latches the acknowledge condition bits at each target cycle end.
// assumes seen-flags are accumulated over the cycle by the caller.
`timescale 1ns/10ps
module ack_capture
    import uut_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    ack_capture_if.cap acq
);
    logic bothAck, neitherAck, vmaFault;
    logic next_bothAck, next_neitherAck, next_vmaFault;

    always_comb begin
        next_bothAck = bothAck;
        next_neitherAck = neitherAck;
        next_vmaFault = vmaFault;
        if (acq.cycleEnd) begin
            next_bothAck = acq.dtackSeen && acq.pavSeen;
            next_neitherAck = !acq.dtackSeen && !acq.pavSeen;
            // slow peripheral cycle begun but valid line gone at strobe rise
            next_vmaFault = acq.pavSeen && !acq.pavAtEnd;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bothAck <= 1'b0;
            neitherAck <= 1'b0;
            vmaFault <= 1'b0;
        end else if (ce) begin
            bothAck <= next_bothAck;
            neitherAck <= next_neitherAck;
            vmaFault <= next_vmaFault;
        end
    end

    assign acq.bothAck = bothAck;
    assign acq.neitherAck = neitherAck;
    assign acq.vmaFault = vmaFault;

    bothAckHold_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !acq.cycleEnd) |=> $stable(bothAck))
        else $error("both-ack bit changed outside cycle end");
    bothAckSet_a: assert property (@(posedge clk) disable iff (!nrst)
        (ce && acq.cycleEnd && acq.dtackSeen && acq.pavSeen) |=> bothAck)
        else $error("both-ack bit not set");
endmodule : ack_capture

// >>> hdl/line_pulser.sv
// line_pulser: drives selected control lines low for a fixed span, then releases.
// assumes start is a one-clock request; a new start while busy is ignored.
`timescale 1ns/10ps
module line_pulser
    import uut_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic startShort,
    input wire logic startLong,
    input wire logic [WCTL_W-1:0] pattern,
    input wire logic [CNT_W-1:0] longCycles,
    output logic [WCTL_W-1:0] lineLevel,
    output logic busy
);
    pulse_state_type state, next_state;
    logic [CNT_W-1:0] count, next_count;
    logic [WCTL_W-1:0] next_lineLevel;

    always_comb begin
        next_state = state;
        next_count = count;
        next_lineLevel = lineLevel;
        case (state)
            PULSE_IDLE: begin
                if (startLong) begin
                    next_state = PULSE_LONG;
                    next_count = longCycles;
                    next_lineLevel = WCTL_IDLE;
                    next_lineLevel[CTL_RESET] = 1'b0;
                end else if (startShort) begin
                    next_state = PULSE_SHORT;
                    next_count = CNT_W'(WCTL_CYCLES);
                    next_lineLevel = pattern;
                end
            end
            PULSE_SHORT, PULSE_LONG: begin
                if (count <= 16'h0001) begin
                    next_state = PULSE_IDLE;
                    next_lineLevel = WCTL_IDLE;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
            default: begin
                next_state = PULSE_IDLE;
                next_lineLevel = WCTL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= PULSE_IDLE;
            count <= '0;
            lineLevel <= WCTL_IDLE;
            busy <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            count <= next_count;
            lineLevel <= next_lineLevel;
            busy <= (next_state != PULSE_IDLE);
        end
    end

    sequence shortStart_s;
        ce && state == PULSE_IDLE && !startLong && startShort;
    endsequence
    shortPulse_a: assert property (@(posedge clk) disable iff (!nrst)
        shortStart_s |=> busy)
        else $error("write-control pulse did not start");
    pulseEnds_a: assert property (@(posedge clk) disable iff (!nrst)
        (state == PULSE_IDLE) |-> (lineLevel == WCTL_IDLE) || $past(!nrst))
        else $error("line held low while idle");
endmodule : line_pulser

// >>> tb/uut_bus_model.sv
// uut_bus_model: target bus side, answers one access cycle per start pulse.
// assumes start is the monitor's one-cycle target cycle start.
`timescale 1ns/10ps
module uut_bus_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [1:0] ackMode,
    output logic strobe_n,
    output logic data_transfer_ack_n_n,
    output logic pav_n
);
    int cnt = 0;
    always @(posedge clk) begin
        if (start) begin
            cnt <= 3;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    // acks only inside the strobe; pulled up otherwise, as on a real target
    assign strobe_n = (cnt == 0);
    assign data_transfer_ack_n_n = strobe_n | ~ackMode[0];
    // mode 10 lets peripheral-valid go one clock before the strobe rises
    assign pav_n = strobe_n | ~ackMode[1] | (ackMode == 2'b10 && cnt == 1);
endmodule : uut_bus_model

// >>> tb/uut_bus_status_monitor_bench.sv
// uut_bus_status_monitor_bench: directed checks of the status monitor.
// assumes the bus model answers every target cycle that the monitor starts.
`timescale 1ns/10ps
module uut_bus_status_monitor_bench
    import uut_monitor_pkg::*;
;
    logic clk = 0, nrst = 0, cmdValid = 0, cmdWrite = 0, vecRdy = 0, pwrFail = 0;
    logic brq_n = 1, bus_error_n_n = 1, uutCyc, strobe_n, data_transfer_ack_n_n, pav_n;
    logic [31:0] cmdAddr = 0;
    logic [15:0] cmdData = 0, rdData;
    logic [1:0] ackMode = 2'b11;
    logic [2:0] irq_n = 3'h7, cpuIrq_n;
    logic [CTL_W-1:0] fault = 0, faultRep;
    logic cpuBr_n, vecCol, bg_n, bgOe, haltOe, rstOut_n, forceAct, actInt, ackErr;
    int err_total = 0, checks_done = 0, cycles = 0, n;
    always #5 clk = ~clk;
    uut_bus_model bus (.clk(clk), .start(uutCyc), .ackMode(ackMode),
        .strobe_n(strobe_n), .data_transfer_ack_n_n(data_transfer_ack_n_n), .pav_n(pav_n));
    uut_bus_status_monitor #(.RESET_CYCLES(20)) dut (.clk(clk), .nrst(nrst), .ce(1'b1),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .rdData(rdData), .uutCycleStart(uutCyc), .data_transfer_ack_n(data_transfer_ack_n_n),
        .peripheral_addr_valid_n(pav_n), .address_strobe_n(strobe_n), .halt_in_n(1'b1),
        .bus_request_n(brq_n), .bus_grant_ack_n(1'b1), .bus_error_n(bus_error_n_n),
        .reset_in_n(1'b1), .irq_priority_bit0_n(irq_n[0]), .irq_priority_bit1_n(irq_n[1]),
        .irq_priority_bit2_n(irq_n[2]), .powerFail(pwrFail), .vectorReady(vecRdy),
        .ctlDriveFault(fault), .cpuHalt_n(), .cpuBusRequest_n(cpuBr_n),
        .cpuBusGrantAck_n(), .cpuIrq_n(cpuIrq_n), .vectorCollect(vecCol), .halt_out_n(),
        .halt_oe(haltOe), .valid_memory_addr_n(), .vma_oe(), .bus_grant_n(bg_n),
        .bus_grant_oe(bgOe), .reset_out_n(rstOut_n), .reset_oe(),
        .activeForceLine(forceAct), .activeInterrupt(actInt), .ackError(ackErr),
        .control_line_fault_report(faultRep));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic wr, input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdWrite <= wr;
        cmdAddr <= a;
        cmdData <= d;
        @(posedge clk);
        cmdValid <= 1'b0;
        #1;
    endtask : cmd
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : idle
    // bounded so a stuck line cannot hang the run
    task automatic plen(input bit rst, output int len);
        len = 0;
        while ((rst ? rstOut_n : bg_n) === 1'b0 && len < 500) begin
            idle(1);
            len++;
        end
    endtask : plen
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        idle(1);
        chk({8'h0, cpuIrq_n, actInt, ackErr, bgOe, bg_n, rstOut_n}, 16'h00e3);
        cmd(1, ADDR_FORCE_MASK, 16'h001f);
        cmd(0, 32'h0000_1000, 16'h0);
        chk(16'(uutCyc), 16'h1);
        idle(8);
        chk(16'(ackErr), 16'h0);
        cmd(0, ADDR_STATUS, 16'h0);
        chk(16'(uutCyc), 16'h0);
        chk(rdData, 16'h277f);
        cmd(0, ADDR_CTL_FAULT, 16'h0);
        chk(rdData, 16'h0000);
        cmd(1, ADDR_FORCE_MASK, 16'h201f);
        idle(2);
        chk(16'(ackErr), 16'h1);
        ackMode <= 2'b01;
        cmd(0, 32'h0000_1000, 16'h0);
        idle(8);
        cmd(0, ADDR_STATUS, 16'h0);
        chk(rdData, 16'h077f);
        chk(16'(ackErr), 16'h0);
        brq_n <= 1'b0;
        idle(3);
        chk({forceAct, cpuBr_n}, 2'b11);
        cmd(1, ADDR_FORCE_ENA, 16'h0003);
        idle(2);
        chk({forceAct, cpuBr_n}, 2'b00);
        bus_error_n_n <= 1'b0;
        idle(3);
        chk(16'(forceAct), 16'h1);
        brq_n <= 1'b1;
        bus_error_n_n <= 1'b1;
        irq_n <= 3'b110;
        vecRdy <= 1'b1;
        idle(3);
        chk({cpuIrq_n, actInt, vecCol}, 5'b11100);
        cmd(1, ADDR_TRAP_CFG, 16'h0001);
        idle(2);
        chk({cpuIrq_n, actInt, vecCol}, 5'b11001);
        cmd(1, ADDR_TRAP_CFG, 16'h0003);
        idle(2);
        chk(16'(actInt), 16'h1);
        cmd(1, ADDR_WRITE_CTL, 16'h001b);
        chk({bgOe, bg_n, haltOe}, 3'b100);
        plen(0, n);
        chk(16'(n), 16'(WCTL_CYCLES));
        cmd(1, ADDR_RESET_CMD, 16'h0);
        plen(1, n);
        chk(16'(n), 16'd20);
        fault <= 13'h0100;
        idle(3);
        cmd(0, ADDR_CTL_FAULT, 16'h0);
        chk(rdData, 16'h0100);
        ackMode <= 2'b10;
        cmd(0, 32'h0000_1000, 16'h0);
        idle(8);
        cmd(0, ADDR_CTL_FAULT, 16'h0);
        chk(rdData, 16'h0102);
        tally_and_finish();
    end
endmodule : uut_bus_status_monitor_bench
